// File: design/rsb_pin_sync.sv
/*
  Pin synchroniser for a group of asynchronous levels.
  Each bit passes four flip-flops; the output follows once the
  second and third stages agree, which filters single-cycle glitches.
  Assumes the inputs are slow levels, not pulses.
*/
`default_nettype none

module rsb_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Asynchronous levels in, settled levels out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic stage1_q;
      logic stage2_q;
      logic stage3_q;
      logic level_q;

      // First stage feeds only the second
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          stage1_q <= 1'b0;
          stage2_q <= 1'b0;
          stage3_q <= 1'b0;
        end
        else
        begin
          stage1_q <= pin_in[gi];
          stage2_q <= stage1_q;
          stage3_q <= stage2_q;
        end
      end

      // Accept a change only when two settled stages agree
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
          level_q <= 1'b0;
        else if (stage2_q == stage3_q)
          level_q <= stage3_q;
      end

      assign level_out[gi] = level_q;
    end
  endgenerate

endmodule

`default_nettype wire

// File: design/rsb_pkg.sv
/*
  Shared constants and types of the receiver read-back register bank:
  register offsets, field layouts, page and measurement-source codes.
  Assumes one 125 MHz system clock and the documented byte-wide
  host register port in front of the bank.
*/
`default_nettype none

package rsb_pkg;

  // Register offsets on the host register port
  localparam logic [7:0] ADDR_GAIN_HEALTH   = 8'h0E;
  localparam logic [7:0] ADDR_SIGNAL_LEVELS = 8'h0F;
  localparam logic [7:0] ADDR_PAGED_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_MEASURE_SEL   = 8'h11;
  localparam logic [7:0] ADDR_CHIP_VERSION  = 8'h13;

  // Reset values and read value of unmapped or empty locations
  localparam logic [7:0] MEASURE_SEL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO         = 8'h00;
  // Arbitrary neutral version code, not tied to any real part
  localparam logic [7:0] VERSION_DEFAULT   = 8'hA5;

  // Status page selector codes
  typedef enum logic [2:0] {
    PAGE_GAIN_LIMIT = 3'b000,
    PAGE_VCO        = 3'b001,
    PAGE_FILTER_CAL = 3'b010,
    PAGE_PILOT_FREQ = 3'b011
  } rsb_page_t;

  // ADC measurement sources
  typedef enum logic [2:0] {
    MEAS_NONE         = 3'b000,
    MEAS_MIXER_DC_I   = 3'b001,
    MEAS_ADC_PIN      = 3'b011,
    MEAS_RF_LEVEL     = 3'b100,
    MEAS_EXT_SUPPLY   = 3'b111
  } rsb_meas_src_t;

  // Host register request, one cycle per access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsb_reg_req_t;

  // Health flags, asynchronous to sys_clk
  typedef struct packed {
    logic rf_level_stable;
    logic synth_locked;
    logic xtal_stable;
  } rsb_health_t;

  // Receiver measurement results, from logic on sys_clk
  typedef struct packed {
    logic [2:0] agc_level;
    logic       in_select;
    logic [3:0] strength_q;
    logic [3:0] strength_i;
    logic [2:0] gain_limit_i;
    logic [2:0] gain_limit_q;
    logic [3:0] vco_range;
    logic       vco_type;
    logic [2:0] vco_voltage;
    logic [3:0] highpass_trim;
    logic [3:0] lowpass_trim;
    logic [7:0] pilot_freq;
  } rsb_rx_status_t;

  // Register layouts
  typedef struct packed {
    logic       rsvd;
    logic [2:0] agc_level;
    logic       in_select;
    logic       rf_level_stable;
    logic       synth_locked;
    logic       xtal_stable;
  } rsb_gain_health_t;

  typedef struct packed {
    logic [3:0] strength_q;
    logic [3:0] strength_i;
  } rsb_levels_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] gain_limit_i;
    logic [2:0] gain_limit_q;
  } rsb_page_agl_t;

  typedef struct packed {
    logic [3:0] vco_range;
    logic       vco_type;
    logic [2:0] vco_voltage;
  } rsb_vco_readback_t;

  typedef struct packed {
    logic [3:0] highpass_trim;
    logic [3:0] lowpass_trim;
  } rsb_page_trim_t;

endpackage

`default_nettype wire

// File: design/rsb_readback_bank.sv
/*
  Receiver read-back register bank: gain and health status, two-channel
  signal strength, paged receiver status, ADC measurement selector and
  version code. Reads answer one cycle after the request.
  Assumes the host port logic delivers one-cycle rd/wr strobes on
  sys_clk, the test-setting register supplies the page selector, and
  rx_start/tx_start are one-cycle pulses from the framing logic.
*/
`default_nettype none

// Behaviour
// - AGC level in bits 6:4, bit 7 zero
// - Bit 3 shows decoding channel, I or Q
// - Bits 2:0 show RF, synthesizer, crystal health
// - Q strength high nibble, I strength low
// - Strengths held from transmission to next reception
// - Page 0 shows I and Q gain limits
// - Page 1 bits 7:4 show VCO range
// - Page 1 VCO type and pin voltage
// - Page 2 shows highpass and lowpass trims
// - Page 3 shows pilot frequency count
// - Selector bits 2:0 route ADC source
// - Selector cleared by reset or chip disable
// - Three-bit page selector chooses paged view
module rsb_readback_bank #(
  parameter logic [7:0] VERSION_CODE = rsb_pkg::VERSION_DEFAULT
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // Chip enable pin, asynchronous
  input  wire logic                    chip_en,
  // Host register port
  input  wire rsb_pkg::rsb_reg_req_t   req,
  output logic [7:0]                   rd_data,
  output logic                         rd_valid,
  // Reception framing events
  input  wire logic                    rx_start,
  input  wire logic                    tx_start,
  // Page selector from the test-setting register
  input  wire logic [2:0]              status_page_sel,
  // Receiver results and asynchronous health flags
  input  wire rsb_pkg::rsb_rx_status_t rx_status,
  input  wire rsb_pkg::rsb_health_t    health_raw,
  // ADC source selection
  output rsb_pkg::rsb_meas_src_t       meas_sel
);
  import rsb_pkg::*;

  logic             chip_en_s;
  rsb_health_t      health_s;
  logic             rx_window_q;
  logic             in_select_q;
  rsb_levels_t      levels_q;
  rsb_meas_src_t    meas_sel_q;
  rsb_meas_src_t    meas_sel_d;
  rsb_gain_health_t gain_view;
  rsb_page_agl_t    agl_view;
  rsb_vco_readback_t vco_view;
  rsb_page_trim_t   trim_view;
  logic [7:0]       paged_view;
  logic [7:0]       rd_data_d;
  logic [7:0]       rd_data_q;
  logic             rd_valid_q;

  // Pins from outside the clock domain
  rsb_pin_sync #(
    .WIDTH     (4)
  ) u_pin_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_in    ({chip_en, health_raw}),
    .level_out ({chip_en_s, health_s})
  );

  // Reception window; a new transmission closes it and wins a tie
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rx_window_q <= 1'b0;
    else if (tx_start)
      rx_window_q <= 1'b0;
    else if (rx_start)
      rx_window_q <= 1'b1;
  end

  // Channel and strengths follow the receiver only inside the window,
  // so software sees frozen values after transmission starts
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      in_select_q <= 1'b0;
      levels_q    <= '0;
    end
    else if ((rx_window_q || rx_start) && !tx_start)
    begin
      in_select_q         <= rx_status.in_select;
      levels_q.strength_q <= rx_status.strength_q;
      levels_q.strength_i <= rx_status.strength_i;
    end
  end

  // Undocumented selector codes fall back to no source
  always_comb
  begin
    unique case (req.wdata[2:0])
      MEAS_MIXER_DC_I: meas_sel_d = MEAS_MIXER_DC_I;
      MEAS_ADC_PIN:    meas_sel_d = MEAS_ADC_PIN;
      MEAS_RF_LEVEL:   meas_sel_d = MEAS_RF_LEVEL;
      MEAS_EXT_SUPPLY: meas_sel_d = MEAS_EXT_SUPPLY;
      default:         meas_sel_d = MEAS_NONE;
    endcase
  end

  // Measurement selector; disable overrides any write
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !chip_en_s)
      meas_sel_q <= rsb_meas_src_t'(MEASURE_SEL_RESET[2:0]);
    else if (req.wr && req.addr == ADDR_MEASURE_SEL)
      meas_sel_q <= meas_sel_d;
  end

  assign meas_sel = meas_sel_q;

  // Register views
  always_comb
  begin
    gain_view.rsvd            = 1'b0;
    gain_view.agc_level       = rx_status.agc_level;
    gain_view.in_select       = in_select_q;
    gain_view.rf_level_stable = health_s.rf_level_stable;
    gain_view.synth_locked    = health_s.synth_locked;
    gain_view.xtal_stable     = health_s.xtal_stable;
    agl_view.rsvd             = 2'b00;
    agl_view.gain_limit_i     = rx_status.gain_limit_i;
    agl_view.gain_limit_q     = rx_status.gain_limit_q;
    vco_view.vco_range        = rx_status.vco_range;
    vco_view.vco_type         = rx_status.vco_type;
    vco_view.vco_voltage      = rx_status.vco_voltage;
    trim_view.highpass_trim   = rx_status.highpass_trim;
    trim_view.lowpass_trim    = rx_status.lowpass_trim;
  end

  // Paged view; unused pages read as zero
  always_comb
  begin
    unique case (status_page_sel)
      PAGE_GAIN_LIMIT: paged_view = agl_view;
      PAGE_VCO:        paged_view = vco_view;
      PAGE_FILTER_CAL: paged_view = trim_view;
      PAGE_PILOT_FREQ: paged_view = rx_status.pilot_freq;
      default:         paged_view = READ_ZERO;
    endcase
  end

  // Read decode; unmapped offsets answer zero
  always_comb
  begin
    unique case (req.addr)
      ADDR_GAIN_HEALTH:   rd_data_d = gain_view;
      ADDR_SIGNAL_LEVELS: rd_data_d = levels_q;
      ADDR_PAGED_STATUS:  rd_data_d = paged_view;
      ADDR_MEASURE_SEL:   rd_data_d = {5'h00, meas_sel_q};
      ADDR_CHIP_VERSION:  rd_data_d = VERSION_CODE;
      default:            rd_data_d = READ_ZERO;
    endcase
  end

  // Read data registered; holds until the next read
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rd_data_q <= READ_ZERO;
    else if (req.rd)
      rd_data_q <= rd_data_d;
  end

  // One-cycle answer strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rd_valid_q <= 1'b0;
    else
      rd_valid_q <= req.rd;
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_gain_agc_field: assert property (
    req.rd && req.addr == ADDR_GAIN_HEALTH |=>
      rd_data[6:4] == $past(rx_status.agc_level) && !rd_data[7])
    else $error("AGC field or reserved bit wrong");

  a_gain_in_select: assert property (
    rx_window_q && !tx_start ##1 req.rd && req.addr == ADDR_GAIN_HEALTH
      |=> rd_data[3] == $past(rx_status.in_select, 2))
    else $error("Channel select bit wrong");

  a_gain_health_bits: assert property (
    req.rd && req.addr == ADDR_GAIN_HEALTH |=>
      rd_data[2:0] == $past(health_s))
    else $error("Health flags wrong");

  a_levels_nibbles: assert property (
    rx_window_q && !tx_start ##1 req.rd && req.addr == ADDR_SIGNAL_LEVELS
      |=> rd_data == {$past(rx_status.strength_q, 2),
                      $past(rx_status.strength_i, 2)})
    else $error("Strength nibbles wrong");

  a_levels_frozen: assert property (
    tx_start ##1 (!rx_start)[*3] |=> $stable(levels_q))
    else $error("Strengths changed outside reception");

  a_page_agl_view: assert property (
    req.rd && req.addr == ADDR_PAGED_STATUS &&
    status_page_sel == PAGE_GAIN_LIMIT |=>
      rd_data == {2'b00, $past(rx_status.gain_limit_i),
                  $past(rx_status.gain_limit_q)})
    else $error("Gain-limit page wrong");

  a_page_vco_view: assert property (
    req.rd && req.addr == ADDR_PAGED_STATUS &&
    status_page_sel == PAGE_VCO |=>
      rd_data == {$past(rx_status.vco_range), $past(rx_status.vco_type),
                  $past(rx_status.vco_voltage)})
    else $error("VCO page wrong");

  a_page_trim_view: assert property (
    req.rd && req.addr == ADDR_PAGED_STATUS &&
    status_page_sel == PAGE_FILTER_CAL |=>
      rd_data == {$past(rx_status.highpass_trim),
                  $past(rx_status.lowpass_trim)})
    else $error("Filter trim page wrong");

  a_page_pilot_view: assert property (
    req.rd && req.addr == ADDR_PAGED_STATUS &&
    status_page_sel == PAGE_PILOT_FREQ |=>
      rd_data == $past(rx_status.pilot_freq))
    else $error("Pilot page wrong");

  a_page_unused_zero: assert property (
    req.rd && req.addr == ADDR_PAGED_STATUS && status_page_sel[2]
      |=> rd_data == READ_ZERO)
    else $error("Unused page not zero");

  a_meas_write: assert property (
    chip_en_s && req.wr && req.addr == ADDR_MEASURE_SEL &&
    req.wdata[2:0] == MEAS_ADC_PIN |=> meas_sel == MEAS_ADC_PIN)
    else $error("Selector write lost");

  a_meas_disable: assert property (
    !chip_en_s |=> meas_sel == MEAS_NONE ##1 meas_sel == MEAS_NONE
      || chip_en_s)
    else $error("Selector not cleared on disable");

  a_version_read: assert property (
    req.rd && req.addr == ADDR_CHIP_VERSION |=> rd_valid &&
      rd_data == VERSION_CODE)
    else $error("Version read wrong");

  // Selector and capture checks beyond the per-field views
  a_meas_undoc_none: assert property (
    chip_en_s && req.wr && req.addr == ADDR_MEASURE_SEL &&
    !(req.wdata[2:0] inside {MEAS_MIXER_DC_I, MEAS_ADC_PIN,
                             MEAS_RF_LEVEL, MEAS_EXT_SUPPLY})
      |=> meas_sel == MEAS_NONE)
    else $error("Undocumented selector code kept");

  a_meas_hold: assert property (
    chip_en_s && !(req.wr && req.addr == ADDR_MEASURE_SEL)
      |=> $stable(meas_sel))
    else $error("Selector changed without a write");

  a_meas_readback: assert property (
    req.rd && req.addr == ADDR_MEASURE_SEL |=>
      rd_data == {5'h00, $past(meas_sel)})
    else $error("Selector read-back wrong");

  a_levels_capture: assert property (
    rx_start && !tx_start |=>
      levels_q == {$past(rx_status.strength_q),
                   $past(rx_status.strength_i)})
    else $error("Strengths not captured at reception start");

  a_window_close: assert property (
    tx_start |=> !rx_window_q)
    else $error("Window open after transmission start");

  c_rx_then_tx: cover property (rx_start ##[1:20] tx_start);
  c_meas_ext: cover property (meas_sel == MEAS_EXT_SUPPLY);
  c_pilot_read: cover property (
    req.rd && req.addr == ADDR_PAGED_STATUS &&
    status_page_sel == PAGE_PILOT_FREQ);
  c_disable_clear: cover property (
    meas_sel != MEAS_NONE ##1 !chip_en_s);
  c_unused_page: cover property (
    req.rd && req.addr == ADDR_PAGED_STATUS && status_page_sel[2]);

endmodule

`default_nettype wire

// File: verif/tb_rsb_readback_bank.sv
/*
  Self-checking bench of the receiver read-back register bank.
  Assumes one 125 MHz clock; the bench drives every input itself at
  the falling edge and reads registers through one-cycle strobes.
*/
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("BAD %s exp %h got %h", nm, ex, got); \
    end \
  end

module tb_rsb_readback_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import rsb_pkg::*;

  // Clock, reset and design ports
  logic           sys_clk;
  logic           rst_n;
  logic           chip_en;
  rsb_reg_req_t   req;
  logic [7:0]     rd_data;
  logic           rd_valid;
  logic           rx_start;
  logic           tx_start;
  logic [2:0]     status_page_sel;
  rsb_rx_status_t rx;
  rsb_health_t    health_raw;
  rsb_meas_src_t  meas_sel;
  int             mismatches;
  int             checks;
  int             cycles;
  logic [7:0]     exp_v;
  logic [2:0]     codes [5];

  rsb_readback_bank dut_u (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .chip_en         (chip_en),
    .req             (req),
    .rd_data         (rd_data),
    .rd_valid        (rd_valid),
    .rx_start        (rx_start),
    .tx_start        (tx_start),
    .status_page_sel (status_page_sel),
    .rx_status       (rx),
    .health_raw      (health_raw),
    .meas_sel        (meas_sel)
  );

  // Free-running clock, 8 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Ceiling well above the roughly 160 cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Read strobe, answer awaited under a bound, then one-cycle check
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    int k;
    @(negedge sys_clk);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    k = 0;
    while (rd_valid !== 1'b1 && k < 3)
    begin
      @(negedge sys_clk);
      k++;
    end
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", ex, rd_data)
    @(negedge sys_clk);
    `CHK("rd_valid low", 1'b0, rd_valid)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask

  // One-cycle framing event, reception start or transmission start
  task automatic ev(input bit is_rx);
    @(negedge sys_clk);
    if (is_rx)
      rx_start = 1'b1;
    else
      tx_start = 1'b1;
    @(negedge sys_clk);
    rx_start = 1'b0;
    tx_start = 1'b0;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    idle(10);
    rst_n = 1'b1;
    idle(8);
  endtask

  initial
  begin
    rst_n = 1'b0;
    chip_en = 1'b1;
    req = '0;
    rx_start = 1'b0;
    tx_start = 1'b0;
    status_page_sel = 3'h0;
    health_raw = 3'b101;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    codes = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7};
    rx = {3'h5, 1'b1, 4'hA, 4'h3, 3'h6, 3'h2, 4'hC, 1'b1, 3'h5,
          4'h9, 4'h4, 8'hA0};
    do_reset();
    // Reset value, version, unmapped and read-only places
    `CHK("meas_sel rst", 3'h0, meas_sel)
    rd(ADDR_MEASURE_SEL, 8'h00);
    wr(ADDR_CHIP_VERSION, 8'h3C);
    rd(ADDR_CHIP_VERSION, VERSION_DEFAULT);
    rd(8'h12, 8'h00);
    // Window open: channel and strengths captured
    ev(1'b1);
    idle(3);
    ev(1'b0);
    rx.in_select = 1'b0;
    rx.strength_q = 4'h1;
    rx.strength_i = 4'hF;
    rx.agc_level = 3'h7;
    idle(3);
    rd(ADDR_GAIN_HEALTH, 8'h7D);
    rd(ADDR_SIGNAL_LEVELS, 8'hA3);
    health_raw = 3'b010;
    ev(1'b1);
    idle(12);
    rd(ADDR_GAIN_HEALTH, 8'h72);
    rd(ADDR_SIGNAL_LEVELS, 8'h1F);
    // Every status page, plus two unused ones
    for (int p = 0; p < 6; p++)
    begin
      status_page_sel = 3'(p);
      case (p)
        0: exp_v = {2'b00, rx.gain_limit_i, rx.gain_limit_q};
        1: exp_v = {rx.vco_range, rx.vco_type, rx.vco_voltage};
        2: exp_v = {rx.highpass_trim, rx.lowpass_trim};
        3: exp_v = rx.pilot_freq;
        default: exp_v = 8'h00;
      endcase
      rd(ADDR_PAGED_STATUS, exp_v);
    end
    // Every documented source code, then an undocumented one
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_MEASURE_SEL, {5'h00, codes[i]});
      `CHK("meas_sel", codes[i], meas_sel)
      rd(ADDR_MEASURE_SEL, {5'h00, codes[i]});
    end
    wr(ADDR_MEASURE_SEL, 8'h02);
    rd(ADDR_MEASURE_SEL, 8'h00);
    // Chip disable clears and blocks the selector
    wr(ADDR_MEASURE_SEL, 8'h04);
    chip_en = 1'b0;
    idle(8);
    `CHK("meas_sel en", 3'h0, meas_sel)
    wr(ADDR_MEASURE_SEL, 8'h07);
    rd(ADDR_MEASURE_SEL, 8'h00);
    chip_en = 1'b1;
    idle(8);
    wr(ADDR_MEASURE_SEL, 8'h01);
    rd(ADDR_MEASURE_SEL, 8'h01);
    // Reset in mid-run clears the selector again
    do_reset();
    `CHK("meas_sel rst2", 3'h0, meas_sel)
    final_report();
  end
endmodule

`default_nettype wire
